// ==== hdl/ldec_consts.svh ====
// Opcode patterns, field codes and execution clock counts for the
// logic and string instruction decoder.
// Assumes opcode bytes are compared on the upper bits noted per entry.
`ifndef LDEC_CONSTS_SVH
`define LDEC_CONSTS_SVH

// Full-byte opcodes
`define OPC_SIGN_EXT_BW   8'h98
`define OPC_SIGN_EXT_WD   8'h99
// Compared on byte[7:2] (d and w below)
`define OPC_AND_RM        6'h08
`define OPC_XOR_RM        6'h0C
// Compared on byte[7:1] (w below; equal sense below for the prefix)
`define OPC_TEST_RM       7'h42
`define OPC_GRP_UNARY     7'h7B
`define OPC_TEST_ACC      7'h54
`define OPC_GRP_IMM       7'h40
`define OPC_XOR_ACC       7'h1A
`define OPC_AND_ACC       7'h12
`define OPC_STR_COPY      7'h52
`define OPC_STR_COMPARE   7'h53
`define OPC_STR_SCAN      7'h57
`define OPC_STR_LOAD      7'h56
`define OPC_STR_STORE     7'h55
`define OPC_REP_PREFIX    7'h79

// Reg field selectors inside the group opcodes
`define REG_TEST_IMM      3'h0
`define REG_INVERT        3'h2
`define REG_AND_IMM       3'h4
`define REG_XOR_IMM       3'h6

// Addressing byte fields
`define MOD_REGISTER      2'h3
`define MOD_DISP8         2'h1
`define MOD_DISP16        2'h2
`define RM_DIRECT         3'h6

// Execution clock counts
`define CLK_SIGN_EXT_BW   24'h000002
`define CLK_SIGN_EXT_WD   24'h000004
`define CLK_RR_REG        24'h000003
`define CLK_RR_MEM        24'h00000A
`define CLK_IMM_REG       24'h000004
`define CLK_IMM_MEM       24'h000010
`define CLK_TEST_IMM_MEM  24'h00000A
`define CLK_ACC_BYTE      24'h000003
`define CLK_ACC_WORD      24'h000004
`define CLK_INV_REG       24'h000003
`define CLK_INV_MEM       24'h00000A
`define CLK_COPY          24'h00000E
`define CLK_COMPARE       24'h000016
`define CLK_SCAN          24'h00000F
`define CLK_LOAD          24'h00000C
`define CLK_STORE         24'h00000A
`define CLK_REP_COPY_BASE 24'h000008
`define CLK_REP_COPY_PER  24'h000008
`define CLK_REP_CMP_BASE  24'h000005
`define CLK_REP_CMP_PER   24'h000016
`define CLK_REP_SCAN_BASE 24'h000005
`define CLK_REP_SCAN_PER  24'h00000F
`define CLK_REP_LOAD_BASE 24'h000006
`define CLK_REP_LOAD_PER  24'h00000B
`define CLK_REP_STOR_BASE 24'h000006
`define CLK_REP_STOR_PER  24'h000009

`endif

// ==== hdl/ldec_pkg.sv ====
// Types shared by the decoder and its classifier.
// Assumes nothing of its surroundings.
package ldec_pkg;

  typedef enum logic [3:0] {
    OP_NONE                    = 4'h0,
    OP_BYTE_TO_WORD_SIGN_EXT   = 4'h1,
    OP_WORD_TO_DOUBLE_SIGN_EXT = 4'h2,
    OP_BITWISE_CONJUNCTION     = 4'h3,
    OP_FLAG_ONLY_CONJUNCTION   = 4'h4,
    OP_EXCLUSIVE_DISJUNCTION   = 4'h5,
    OP_INVERT_OPERAND          = 4'h6,
    OP_STRING_COPY             = 4'h7,
    OP_STRING_COMPARE          = 4'h8,
    OP_STRING_SCAN             = 4'h9,
    OP_STRING_LOAD             = 4'hA,
    OP_STRING_STORE            = 4'hB
  } op_t;

  typedef enum logic [1:0] {
    GRP_NONE  = 2'h0,
    GRP_UNARY = 2'h1,
    GRP_IMM   = 2'h2
  } group_t;

  typedef struct packed {
    op_t    op;
    group_t group;
    logic   legal;
    logic   prefix;
    logic   has_modrm;
    logic   has_imm;
    logic   acc_form;
    logic   is_string;
    logic   dir_form;
    logic   dir_bit;
    logic   word_bit;
  } first_info_t;

  typedef enum logic [6:0] {
    S_OPCODE = 7'h01,
    S_MODRM  = 7'h02,
    S_DISP   = 7'h04,
    S_IMM_LO = 7'h08,
    S_IMM_HI = 7'h10,
    S_START  = 7'h20,
    S_EXEC   = 7'h40
  } state_t;

endpackage

// ==== hdl/ldec_links_if.sv ====
// Internal links of the decoder: first-byte classification and the
// execution timer.
// Assumes a single clock; the interfaces carry no clocked logic.
`timescale 1ns/100ps
`default_nettype none

interface class_if;
  logic [7:0]          byte_v;
  ldec_pkg::first_info_t info;
  modport classifier (input byte_v, output info);
  modport user       (output byte_v, input info);
endinterface

interface timer_if;
  logic        load;
  logic [23:0] count;
  logic        busy;
  logic        expire;
  modport timer (input load, input count, output busy, output expire);
  modport user  (output load, output count, input busy, input expire);
endinterface

`default_nettype wire

// ==== hdl/opcode_classifier.sv ====
// Combinational classification of a first opcode byte.
// Assumes the byte is stable while the decoder samples the result.
`timescale 1ns/100ps
`default_nettype none
`include "ldec_consts.svh"

module opcode_classifier (
  class_if.classifier bus
);

  function automatic ldec_pkg::first_info_t classify(input logic [7:0] b);
    ldec_pkg::first_info_t r;
    r           = '0;
    r.op        = ldec_pkg::OP_NONE;
    r.group     = ldec_pkg::GRP_NONE;
    r.legal     = 1'b1;
    r.word_bit  = b[0];
    r.dir_bit   = b[1];
    if (b == `OPC_SIGN_EXT_BW) begin
      r.op       = ldec_pkg::OP_BYTE_TO_WORD_SIGN_EXT;
      r.word_bit = 1'b0;
    end else if (b == `OPC_SIGN_EXT_WD) begin
      r.op       = ldec_pkg::OP_WORD_TO_DOUBLE_SIGN_EXT;
      r.word_bit = 1'b1;
    end else if (b[7:2] == `OPC_AND_RM) begin
      r.op        = ldec_pkg::OP_BITWISE_CONJUNCTION;
      r.has_modrm = 1'b1;
      r.dir_form  = 1'b1;
    end else if (b[7:2] == `OPC_XOR_RM) begin
      r.op        = ldec_pkg::OP_EXCLUSIVE_DISJUNCTION;
      r.has_modrm = 1'b1;
      r.dir_form  = 1'b1;
    end else if (b[7:1] == `OPC_TEST_RM) begin
      r.op        = ldec_pkg::OP_FLAG_ONLY_CONJUNCTION;
      r.has_modrm = 1'b1;
    end else if (b[7:1] == `OPC_GRP_UNARY) begin
      r.group     = ldec_pkg::GRP_UNARY;
      r.has_modrm = 1'b1;
    end else if (b[7:1] == `OPC_GRP_IMM) begin
      r.group     = ldec_pkg::GRP_IMM;
      r.has_modrm = 1'b1;
      r.has_imm   = 1'b1;
    end else if (b[7:1] == `OPC_TEST_ACC) begin
      r.op       = ldec_pkg::OP_FLAG_ONLY_CONJUNCTION;
      r.has_imm  = 1'b1;
      r.acc_form = 1'b1;
    end else if (b[7:1] == `OPC_XOR_ACC) begin
      r.op       = ldec_pkg::OP_EXCLUSIVE_DISJUNCTION;
      r.has_imm  = 1'b1;
      r.acc_form = 1'b1;
    end else if (b[7:1] == `OPC_AND_ACC) begin
      r.op       = ldec_pkg::OP_BITWISE_CONJUNCTION;
      r.has_imm  = 1'b1;
      r.acc_form = 1'b1;
    end else if (b[7:1] == `OPC_STR_COPY) begin
      r.op        = ldec_pkg::OP_STRING_COPY;
      r.is_string = 1'b1;
    end else if (b[7:1] == `OPC_STR_COMPARE) begin
      r.op        = ldec_pkg::OP_STRING_COMPARE;
      r.is_string = 1'b1;
    end else if (b[7:1] == `OPC_STR_SCAN) begin
      r.op        = ldec_pkg::OP_STRING_SCAN;
      r.is_string = 1'b1;
    end else if (b[7:1] == `OPC_STR_LOAD) begin
      r.op        = ldec_pkg::OP_STRING_LOAD;
      r.is_string = 1'b1;
    end else if (b[7:1] == `OPC_STR_STORE) begin
      r.op        = ldec_pkg::OP_STRING_STORE;
      r.is_string = 1'b1;
    end else if (b[7:1] == `OPC_REP_PREFIX) begin
      r.prefix = 1'b1;
    end else begin
      r.legal = 1'b0;
    end
    return r;
  endfunction

  assign bus.info = classify(bus.byte_v);

endmodule

`default_nettype wire

// ==== hdl/exec_timer.sv ====
// Down-counter that holds the decoder busy for an instruction's clocks.
// Assumes load is a one-cycle pulse with a count of at least one.
`timescale 1ns/100ps
`default_nettype none

module exec_timer (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  timer_if.timer    tmr
);

  logic [23:0] remain_reg;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      remain_reg <= 24'h000000;
    end else if (tmr.load) begin
      remain_reg <= tmr.count;
    end else if (remain_reg != 24'h000000) begin
      remain_reg <= remain_reg - 24'h000001;
    end
  end

  assign tmr.busy   = (remain_reg != 24'h000000);
  assign tmr.expire = (remain_reg == 24'h000001);

endmodule

`default_nettype wire

// ==== hdl/logic_string_op_decoder.sv ====
// Decoder for the logic and string instruction groups: takes opcode
// bytes, collects addressing and immediate bytes, and holds each decoded
// operation busy for its execution clock count; repeated string forms take a base plus a per-iteration cost times count_reg_i.
// Assumes bytes arrive from fetch logic on clk_i with valid/ready, and
// that count_reg_i is the live count register from the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "ldec_consts.svh"

module logic_string_op_decoder (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [7:0]  byte_i,
  input  wire logic        byte_valid_i,
  output logic             byte_ready_o,
  input  wire logic [15:0] count_reg_i,
  output var ldec_pkg::op_t op_o,
  output logic             word_o,
  output logic             dir_to_reg_o,
  output logic             mem_operand_o,
  output logic             repeat_o,
  output logic             equal_sense_o,
  output logic             writes_result_o,
  output logic [7:0]       modrm_o,
  output logic [15:0]      imm_o,
  output logic [23:0]      clocks_o,
  output logic             busy_o,
  output logic             done_o,
  output logic             illegal_o
);

  class_if cls ();
  timer_if tmr ();

  opcode_classifier u_classifier (
    .bus (cls.classifier)
  );

  exec_timer u_timer (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .tmr       (tmr.timer)
  );

  ldec_pkg::state_t      state_reg;
  ldec_pkg::state_t      state_next;
  ldec_pkg::first_info_t info_reg;
  ldec_pkg::op_t         op_reg;
  logic [7:0]            modrm_reg;
  logic [15:0]           imm_reg;
  logic [1:0]            disp_left_reg;
  logic                  rep_reg;
  logic                  sense_reg;
  logic                  take;
  logic                  group_bad;
  ldec_pkg::op_t         group_op;
  logic                  group_imm;
  logic [1:0]            disp_len;

  // Register operand only when mod is 11
  function automatic logic is_memory(input logic [7:0] m);
    return m[7:6] != `MOD_REGISTER;
  endfunction

  // Displacement bytes that follow the addressing byte
  function automatic logic [1:0] disp_bytes(input logic [7:0] m);
    logic [1:0] n;
    n = 2'h0;
    if (m[7:6] == `MOD_DISP8) begin
      n = 2'h1;
    end else if (m[7:6] == `MOD_DISP16) begin
      n = 2'h2;
    end else if (m[7:6] == 2'h0 && m[2:0] == `RM_DIRECT) begin
      n = 2'h2;
    end
    return n;
  endfunction

  function automatic logic [23:0] exec_clocks(
    input ldec_pkg::op_t op,
    input logic          mem,
    input logic          word,
    input logic          count_loop_prefix,
    input logic          acc,
    input logic          imm,
    input logic [15:0]   n
  );
    logic [23:0] base;
    logic [23:0] per;
    base = `CLK_RR_REG;
    per  = 24'h000000;
    unique case (op)
      ldec_pkg::OP_BYTE_TO_WORD_SIGN_EXT: begin
        base = `CLK_SIGN_EXT_BW;
      end
      ldec_pkg::OP_WORD_TO_DOUBLE_SIGN_EXT: begin
        base = `CLK_SIGN_EXT_WD;
      end
      ldec_pkg::OP_BITWISE_CONJUNCTION,
      ldec_pkg::OP_EXCLUSIVE_DISJUNCTION: begin
        if (acc) begin
          base = word ? `CLK_ACC_WORD : `CLK_ACC_BYTE;
        end else if (imm) begin
          base = mem ? `CLK_IMM_MEM : `CLK_IMM_REG;
        end else begin
          base = mem ? `CLK_RR_MEM : `CLK_RR_REG;
        end
      end
      ldec_pkg::OP_FLAG_ONLY_CONJUNCTION: begin
        if (acc) begin
          base = word ? `CLK_ACC_WORD : `CLK_ACC_BYTE;
        end else if (imm) begin
          base = mem ? `CLK_TEST_IMM_MEM : `CLK_IMM_REG;
        end else begin
          base = mem ? `CLK_RR_MEM : `CLK_RR_REG;
        end
      end
      ldec_pkg::OP_INVERT_OPERAND: begin
        base = mem ? `CLK_INV_MEM : `CLK_INV_REG;
      end
      ldec_pkg::OP_STRING_COPY: begin
        base = count_loop_prefix ? `CLK_REP_COPY_BASE : `CLK_COPY;
        per  = count_loop_prefix ? `CLK_REP_COPY_PER : 24'h000000;
      end
      ldec_pkg::OP_STRING_COMPARE: begin
        base = count_loop_prefix ? `CLK_REP_CMP_BASE : `CLK_COMPARE;
        per  = count_loop_prefix ? `CLK_REP_CMP_PER : 24'h000000;
      end
      ldec_pkg::OP_STRING_SCAN: begin
        base = count_loop_prefix ? `CLK_REP_SCAN_BASE : `CLK_SCAN;
        per  = count_loop_prefix ? `CLK_REP_SCAN_PER : 24'h000000;
      end
      ldec_pkg::OP_STRING_LOAD: begin
        base = count_loop_prefix ? `CLK_REP_LOAD_BASE : `CLK_LOAD;
        per  = count_loop_prefix ? `CLK_REP_LOAD_PER : 24'h000000;
      end
      ldec_pkg::OP_STRING_STORE: begin
        base = count_loop_prefix ? `CLK_REP_STOR_BASE : `CLK_STORE;
        per  = count_loop_prefix ? `CLK_REP_STOR_PER : 24'h000000;
      end
      default: begin
        base = `CLK_RR_REG;
      end
    endcase
    // Widest case stays far below 2^24, so the product never wraps
    return base + per * {8'h00, n};
  endfunction

  assign cls.byte_v = byte_i;

  assign byte_ready_o = (state_reg == ldec_pkg::S_OPCODE) ||
                        (state_reg == ldec_pkg::S_MODRM)  ||
                        (state_reg == ldec_pkg::S_DISP)   ||
                        (state_reg == ldec_pkg::S_IMM_LO) ||
                        (state_reg == ldec_pkg::S_IMM_HI);
  assign take = byte_valid_i && byte_ready_o;

  // Reg field of the addressing byte picks the operation in the groups
  always_comb begin
    group_op  = ldec_pkg::OP_NONE;
    group_imm = 1'b0;
    group_bad = 1'b0;
    if (info_reg.group == ldec_pkg::GRP_UNARY) begin
      if (byte_i[5:3] == `REG_TEST_IMM) begin
        group_op  = ldec_pkg::OP_FLAG_ONLY_CONJUNCTION;
        group_imm = 1'b1;
      end else if (byte_i[5:3] == `REG_INVERT) begin
        group_op  = ldec_pkg::OP_INVERT_OPERAND;
      end else begin
        group_bad = 1'b1;
      end
    end else if (info_reg.group == ldec_pkg::GRP_IMM) begin
      group_imm = 1'b1;
      if (byte_i[5:3] == `REG_XOR_IMM) begin
        group_op = ldec_pkg::OP_EXCLUSIVE_DISJUNCTION;
      end else if (byte_i[5:3] == `REG_AND_IMM) begin
        group_op = ldec_pkg::OP_BITWISE_CONJUNCTION;
      end else begin
        group_bad = 1'b1;
      end
    end else begin
      group_op  = info_reg.op;
      group_imm = info_reg.has_imm;
    end
  end

  assign disp_len = disp_bytes(byte_i);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ldec_pkg::S_OPCODE: begin
        if (take && cls.info.legal && !cls.info.prefix) begin
          if (cls.info.has_modrm) begin
            state_next = ldec_pkg::S_MODRM;
          end else if (cls.info.has_imm) begin
            state_next = ldec_pkg::S_IMM_LO;
          end else begin
            state_next = ldec_pkg::S_START;
          end
        end
      end
      ldec_pkg::S_MODRM: begin
        if (take) begin
          if (group_bad) begin
            state_next = ldec_pkg::S_OPCODE;
          end else if (disp_len != 2'h0) begin
            state_next = ldec_pkg::S_DISP;
          end else if (group_imm) begin
            state_next = ldec_pkg::S_IMM_LO;
          end else begin
            state_next = ldec_pkg::S_START;
          end
        end
      end
      ldec_pkg::S_DISP: begin
        if (take && disp_left_reg == 2'h1) begin
          state_next = info_reg.has_imm ? ldec_pkg::S_IMM_LO
                                        : ldec_pkg::S_START;
        end
      end
      ldec_pkg::S_IMM_LO: begin
        if (take) begin
          state_next = info_reg.word_bit ? ldec_pkg::S_IMM_HI
                                         : ldec_pkg::S_START;
        end
      end
      ldec_pkg::S_IMM_HI: begin
        if (take) begin
          state_next = ldec_pkg::S_START;
        end
      end
      ldec_pkg::S_START: begin
        state_next = ldec_pkg::S_EXEC;
      end
      ldec_pkg::S_EXEC: begin
        if (tmr.expire) begin
          state_next = ldec_pkg::S_OPCODE;
        end
      end
      default: begin
        state_next = ldec_pkg::S_OPCODE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= ldec_pkg::S_OPCODE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Prefix is remembered until the string operation it qualifies expires; a non-string opcode clears it
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rep_reg   <= 1'b0;
      sense_reg <= 1'b0;
    end else if (take && state_reg == ldec_pkg::S_OPCODE) begin
      if (cls.info.prefix) begin
        rep_reg   <= 1'b1;
        sense_reg <= byte_i[0];
      end else if (!cls.info.is_string) begin
        rep_reg   <= 1'b0;
      end
    end else if (state_reg == ldec_pkg::S_START && !info_reg.is_string) begin
      rep_reg <= 1'b0;
    end else if (tmr.expire) begin
      rep_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      info_reg      <= '0;
      op_reg        <= ldec_pkg::OP_NONE;
      modrm_reg     <= 8'hC0;
      imm_reg       <= 16'h0000;
      disp_left_reg <= 2'h0;
    end else if (take) begin
      unique case (state_reg)
        ldec_pkg::S_OPCODE: begin
          info_reg  <= cls.info;
          op_reg    <= cls.info.op;
          modrm_reg <= 8'hC0;
          imm_reg   <= 16'h0000;
        end
        ldec_pkg::S_MODRM: begin
          modrm_reg        <= byte_i;
          op_reg           <= group_op;
          info_reg.has_imm <= group_imm;
          disp_left_reg    <= disp_len;
        end
        ldec_pkg::S_DISP: begin
          disp_left_reg <= disp_left_reg - 2'h1;
        end
        ldec_pkg::S_IMM_LO: begin
          imm_reg[7:0] <= byte_i;
        end
        ldec_pkg::S_IMM_HI: begin
          imm_reg[15:8] <= byte_i;
        end
        default: begin
          imm_reg <= imm_reg;
        end
      endcase
    end
  end

  assign tmr.load  = (state_reg == ldec_pkg::S_START);
  assign tmr.count = exec_clocks(op_reg, is_memory(modrm_reg),
                                 info_reg.word_bit, rep_reg,
                                 info_reg.acc_form, info_reg.has_imm,
                                 count_reg_i);

  // Outputs are captured once at start and held through execution
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      op_o            <= ldec_pkg::OP_NONE;
      word_o          <= 1'b0;
      dir_to_reg_o    <= 1'b0;
      mem_operand_o   <= 1'b0;
      repeat_o        <= 1'b0;
      equal_sense_o   <= 1'b0;
      writes_result_o <= 1'b0;
      modrm_o         <= 8'h00;
      imm_o           <= 16'h0000;
      clocks_o        <= 24'h000000;
    end else if (state_reg == ldec_pkg::S_START) begin
      op_o            <= op_reg;
      word_o          <= info_reg.word_bit;
      dir_to_reg_o    <= info_reg.dir_form & info_reg.dir_bit;
      mem_operand_o   <= info_reg.has_modrm & is_memory(modrm_reg);
      repeat_o        <= rep_reg & info_reg.is_string;
      equal_sense_o   <= sense_reg & rep_reg & info_reg.is_string;
      writes_result_o <= (op_reg != ldec_pkg::OP_FLAG_ONLY_CONJUNCTION) &&
                         (op_reg != ldec_pkg::OP_STRING_COMPARE) &&
                         (op_reg != ldec_pkg::OP_STRING_SCAN);
      modrm_o         <= modrm_reg;
      imm_o           <= imm_reg;
      clocks_o        <= tmr.count;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      done_o    <= 1'b0;
      illegal_o <= 1'b0;
    end else begin
      done_o    <= (state_reg == ldec_pkg::S_EXEC) && tmr.expire;
      illegal_o <= take &&
                   (((state_reg == ldec_pkg::S_OPCODE) && !cls.info.legal) ||
                    ((state_reg == ldec_pkg::S_MODRM) && group_bad));
    end
  end

  assign busy_o = tmr.busy;

endmodule

`default_nettype wire

// ==== testbench/fetch_queue_model.sv ====
// Fetch queue model: offers queued bytes with random stalls.
// Assumes the decoder takes a byte at a rising edge with valid and ready.
`timescale 1ns/100ps
`default_nettype none
module fetch_queue_model (
  input  wire logic  clk_i,
  input  wire logic  ready_i,
  output logic       valid_o = 1'b0,
  output logic [7:0] byte_o = 8'h00
);
  logic [7:0] q[$];
  logic       took_reg = 1'b0;
  integer     seed = 22;
  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask
  always @(posedge clk_i) took_reg <= valid_o && ready_i;
  // Offer is held until taken; a released line shows the inverse
  always @(negedge clk_i) begin
    if (took_reg) q.delete(0);
    if (took_reg || !valid_o) begin
      valid_o = q.size() > 0 && $random(seed) % 4 != 0;
      byte_o = valid_o ? q[0] : ~byte_o;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/ldec_props.sv ====
// Port checker for the logic/string decoder.
// Assumes it is bound to the decoder top; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module ldec_props (
  input wire logic          clk_i,
  input wire logic          sys_rst_i,
  input wire ldec_pkg::op_t op_o,
  input wire logic          word_o,
  input wire logic          repeat_o,
  input wire logic          writes_result_o,
  input wire logic [23:0]   clocks_o,
  input wire logic          byte_ready_o,
  input wire logic          busy_o,
  input wire logic          done_o
);
  logic [23:0] cnt_reg;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) cnt_reg <= 24'h000000;
    else cnt_reg <= busy_o ? cnt_reg + 24'h000001 : 24'h000000;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_busy_refuses_bytes: assert property (busy_o |-> !byte_ready_o)
    else $error("byte ready while busy");
  a_ext_byte_time: assert property ($rose(busy_o) && op_o ==
    ldec_pkg::OP_BYTE_TO_WORD_SIGN_EXT |-> clocks_o == 24'h000002
    ##1 busy_o ##1 (!busy_o && done_o)) else $error("extend byte timing");
  a_ext_word_time: assert property ($rose(busy_o) && op_o ==
    ldec_pkg::OP_WORD_TO_DOUBLE_SIGN_EXT |-> clocks_o == 24'h000004
    && word_o) else $error("extend word clocks");
  a_copy_once_time: assert property ($rose(busy_o) && !repeat_o &&
    op_o == ldec_pkg::OP_STRING_COPY |-> clocks_o == 24'h00000E)
    else $error("copy clocks");
  a_compare_once: assert property ($rose(busy_o) && !repeat_o &&
    op_o == ldec_pkg::OP_STRING_COMPARE |-> clocks_o == 24'h000016
    && !writes_result_o) else $error("compare clocks");
  a_scan_once: assert property ($rose(busy_o) && op_o ==
    ldec_pkg::OP_STRING_SCAN && !repeat_o |-> clocks_o == 24'h00000F)
    else $error("scan clocks");
  a_load_once: assert property ($rose(busy_o) && op_o ==
    ldec_pkg::OP_STRING_LOAD && !repeat_o |-> clocks_o == 24'h00000C)
    else $error("load clocks");
  a_store_once: assert property ($rose(busy_o) && op_o ==
    ldec_pkg::OP_STRING_STORE && !repeat_o |-> clocks_o == 24'h00000A)
    else $error("store clocks");
  a_flag_no_write: assert property (busy_o && op_o ==
    ldec_pkg::OP_FLAG_ONLY_CONJUNCTION |-> !writes_result_o)
    else $error("flag-only op writes result");
  a_busy_length: assert property ($fell(busy_o) |->
    cnt_reg == clocks_o && done_o) else $error("busy length wrong");
endmodule
bind logic_string_op_decoder ldec_props i_props (.clk_i, .sys_rst_i,
  .op_o, .word_o, .repeat_o, .writes_result_o, .clocks_o, .byte_ready_o,
  .busy_o, .done_o);
`default_nettype wire

// ==== testbench/logic_string_op_decoder_bench.sv ====
// Self-checking bench for the logic/string decoder.
// Assumes the fetch model and the checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module logic_string_op_decoder_bench;
  localparam ldec_pkg::op_t
    BW = ldec_pkg::OP_BYTE_TO_WORD_SIGN_EXT,
    WD = ldec_pkg::OP_WORD_TO_DOUBLE_SIGN_EXT,
    CJ = ldec_pkg::OP_BITWISE_CONJUNCTION,
    TS = ldec_pkg::OP_FLAG_ONLY_CONJUNCTION,
    XR = ldec_pkg::OP_EXCLUSIVE_DISJUNCTION,
    IV = ldec_pkg::OP_INVERT_OPERAND,
    CP = ldec_pkg::OP_STRING_COPY,
    CM = ldec_pkg::OP_STRING_COMPARE,
    SC = ldec_pkg::OP_STRING_SCAN,
    LD = ldec_pkg::OP_STRING_LOAD,
    ST = ldec_pkg::OP_STRING_STORE;
  logic          clk_i = 1'b0;
  logic          sys_rst_i = 1'b1;
  logic [15:0]   count_reg_i = 16'h0000;
  logic [15:0]   imm_o;
  logic [7:0]    byte_i, modrm_o;
  logic [23:0]   clocks_o;
  logic          byte_valid_i, byte_ready_o, word_o, dir_to_reg_o, done_o;
  logic          mem_operand_o, repeat_o, equal_sense_o, writes_result_o;
  logic          busy_o, illegal_o;
  ldec_pkg::op_t op_o;
  integer        seed = 22;
  int            errors = 0, comparisons = 0, cyc = 0, k;
  logic_string_op_decoder i_dut (.clk_i, .sys_rst_i, .byte_i, .byte_valid_i,
    .byte_ready_o, .count_reg_i, .op_o, .word_o, .dir_to_reg_o,
    .mem_operand_o, .repeat_o, .equal_sense_o, .writes_result_o, .modrm_o,
    .imm_o, .clocks_o, .busy_o, .done_o, .illegal_o);
  fetch_queue_model i_fq (.clk_i, .ready_i(byte_ready_o),
    .valid_o(byte_valid_i), .byte_o(byte_i));
  initial forever #25 clk_i = ~clk_i;
  task automatic test_done;
    if (errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      test_done;
    end
  end
  task automatic chk(input string nm, input logic [23:0] e, g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Model: clocks are base plus per-iteration cost times the count
  task automatic run(input logic [47:0] b, input int len,
      input ldec_pkg::op_t op, input int base, per, input logic w, wr,
      input logic [1:0] dm, input logic [23:0] mi);
    int n, c;
    n = $random(seed) & 7;
    count_reg_i = n[15:0];
    for (int i = len - 1; i >= 0; i--) i_fq.push(b[8*i+:8]);
    c = 0;
    do begin
      @(negedge clk_i);
      c += (busy_o === 1'b1);
    end while (done_o !== 1'b1 && c < 400);
    chk("op", 24'(op), 24'(op_o));
    chk("clocks", 24'(base + per * n), clocks_o);
    chk("busy", 24'(base + per * n), 24'(c));
    chk("word", 24'(w), 24'(word_o));
    chk("write", 24'(wr), 24'(writes_result_o));
    chk("repeat", 24'(per != 0), 24'(repeat_o));
    chk("sense", 24'(per != 0 && b[8*len-8]), 24'(equal_sense_o));
    chk("dir", 24'(dm[1]), 24'(dir_to_reg_o));
    chk("mem", 24'(dm[0]), 24'(mem_operand_o));
    chk("modrm", 24'(mi[23:16]), 24'(modrm_o));
    chk("imm", 24'(mi[15:0]), 24'(imm_o));
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    @(negedge clk_i);
    sys_rst_i = 1'b0;
    run(48'h98, 1, BW, 2, 0, 0, 1, 2'h0, 24'hC00000);
    run(48'h99, 1, WD, 4, 0, 1, 1, 2'h0, 24'hC00000);
    run(48'h20C0, 2, CJ, 3, 0, 0, 1, 2'h0, 24'hC00000);
    run(48'h23063412, 4, CJ, 10, 0, 1, 1, 2'h3, 24'h060000);
    run(48'h844005, 3, TS, 10, 0, 0, 0, 2'h1, 24'h400000);
    run(48'hF6C055, 3, TS, 4, 0, 0, 0, 2'h0, 24'hC00055);
    run(48'hF70600103412, 6, TS, 10, 0, 1, 0, 2'h1, 24'h061234);
    run(48'hA833, 2, TS, 3, 0, 0, 0, 2'h0, 24'hC00033);
    run(48'hA91122, 3, TS, 4, 0, 1, 0, 2'h0, 24'hC02211);
    run(48'h30C0, 2, XR, 3, 0, 0, 1, 2'h0, 24'hC00000);
    run(48'h81303412, 4, XR, 16, 0, 1, 1, 2'h1, 24'h301234);
    run(48'h3477, 2, XR, 3, 0, 0, 1, 2'h0, 24'hC00077);
    run(48'h351122, 3, XR, 4, 0, 1, 1, 2'h0, 24'hC02211);
    run(48'hF6D0, 2, IV, 3, 0, 0, 1, 2'h0, 24'hD00000);
    run(48'hF710, 2, IV, 10, 0, 1, 1, 2'h1, 24'h100000);
    run(48'hA4, 1, CP, 14, 0, 0, 1, 2'h0, 24'hC00000);
    run(48'hA6, 1, CM, 22, 0, 0, 0, 2'h0, 24'hC00000);
    run(48'hAF, 1, SC, 15, 0, 1, 0, 2'h0, 24'hC00000);
    run(48'hAC, 1, LD, 12, 0, 0, 1, 2'h0, 24'hC00000);
    run(48'hAB, 1, ST, 10, 0, 1, 1, 2'h0, 24'hC00000);
    run(48'hA5, 1, CP, 14, 0, 1, 1, 2'h0, 24'hC00000);
    run(48'h80E012, 3, CJ, 4, 0, 0, 1, 2'h0, 24'hE00012);
    run(48'h251122, 3, CJ, 4, 0, 1, 1, 2'h0, 24'hC02211);
    run(48'hF2A5, 2, CP, 8, 8, 1, 1, 2'h0, 24'hC00000);
    run(48'hF2AD, 2, LD, 6, 11, 1, 1, 2'h0, 24'hC00000);
    run(48'hF2AA, 2, ST, 6, 9, 0, 1, 2'h0, 24'hC00000);
    run(48'hF3A6, 2, CM, 5, 22, 0, 0, 2'h0, 24'hC00000);
    run(48'hF2A7, 2, CM, 5, 22, 1, 0, 2'h0, 24'hC00000);
    run(48'hF2AE, 2, SC, 5, 15, 0, 0, 2'h0, 24'hC00000);
    // Bad group reg field, then an unknown first byte
    i_fq.push(8'hF6);
    i_fq.push(8'hC8);
    i_fq.push(8'h00);
    k = 0;
    repeat (30) begin
      @(negedge clk_i);
      k += (illegal_o === 1'b1);
    end
    chk("illegal", 24'h000002, 24'(k));
    test_done;
  end
endmodule
`default_nettype wire
